// file: include/psld_pkg.sv
// Package: constants shared by the port status lamp driver files
package psld_pkg;

  localparam int PORTS          = 8;
  localparam int GROUP          = 4;
  localparam int SEL_W          = 2;
  localparam int PHASE_W        = 4;
  localparam int WB_DW          = 32;
  localparam int WB_AW          = 4;
  localparam int WB_SW          = 4;

  // Clock rate and lamp timing, derived counts below
  localparam int CLK_KHZ        = 100_000;
  localparam int BLINK_HALF_MS  = 50;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
  localparam int SCAN_STEP_US   = 250;
  localparam int SCAN_STEP_CYC  = (SCAN_STEP_US * CLK_KHZ) / 1000;

  // Lamp meaning codes
  localparam logic [SEL_W-1:0] SEL_SPLIT_TXRX = 2'h0;
  localparam logic [SEL_W-1:0] SEL_LINK_RX    = 2'h1;
  localparam logic [SEL_W-1:0] SEL_SPLIT_COL  = 2'h2;
  localparam logic [SEL_W-1:0] SEL_LINK_TXRX  = 2'h3;
  localparam logic [SEL_W-1:0] SEL_RESET      = SEL_LINK_TXRX;
  localparam logic             STYLE_SCAN     = 1'h0;
  localparam logic             STYLE_DIRECT   = 1'h1;

  // Register byte addresses
  localparam logic [WB_AW-1:0] REG_CTRL       = 4'h0;
  localparam logic [WB_AW-1:0] REG_STATUS     = 4'h4;

  // Control fields
  localparam int               CTRL_EN_BIT    = 0;
  localparam int               CTRL_TEST_BIT  = 1;
  localparam logic             CTRL_EN_RST    = 1'h1;
  localparam logic             CTRL_TEST_RST  = 1'h0;

  // Status fields
  localparam int               STAT_STYLE_BIT = 0;
  localparam int               STAT_SEL_LSB   = 1;
  localparam int               STAT_BLINK_BIT = 3;
  localparam int               STAT_CAPT_BIT  = 4;
  localparam int               STAT_LINK_LSB  = 8;

endpackage : psld_pkg

// file: rtl/psld_blink.sv
// Free-running flash phase generator for the lamps
`timescale 1ns/1ps
`default_nettype none

module psld_blink
  import psld_pkg::*;
#(
  parameter int HALF_CYC = BLINK_HALF_CYC
)
(
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  output var  logic blink_phase
);

  localparam int CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          phase;
  } psld_blink_s;

  psld_blink_s q;
  psld_blink_s d;

  always_comb
  begin
    d = q;
    if (ce)
    begin
      if (q.cnt == LAST)
      begin
        d.cnt   = '0;
        d.phase = ~q.phase;
      end
      else
      begin
        d.cnt = q.cnt + CW'(1);
      end
    end
    if (sys_rst)
    begin
      d = '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    q <= d;
  end

  assign blink_phase = q.phase;

endmodule // psld_blink

`default_nettype wire

// file: rtl/psld_scan.sv
// Scan-mode drive: 12 pins serve 32 lamps, one port of each half per phase
`timescale 1ns/1ps
`default_nettype none

module psld_scan
  import psld_pkg::*;
#(
  parameter int STEP_CYC = SCAN_STEP_CYC
)
(
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               ce,
  input  wire logic               run,
  input  wire logic [PORTS-1:0]   link_lamp,
  input  wire logic [PORTS-1:0]   rate_lamp,
  input  wire logic [PORTS-1:0]   duplex_lamp,
  input  wire logic [PORTS-1:0]   rx_lamp,
  output var  logic [PHASE_W-1:0] scan_phase,
  output var  logic               scan_link_a,
  output var  logic               scan_link_b,
  output var  logic               scan_rate_a,
  output var  logic               scan_rate_b,
  output var  logic               scan_duplex_a,
  output var  logic               scan_duplex_b,
  output var  logic               scan_rx_a,
  output var  logic               scan_rx_b
);

  localparam int CW = $clog2(STEP_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(STEP_CYC - 1);

  typedef struct packed {
    logic [CW-1:0]      cnt;
    logic [1:0]         idx;
    logic [PHASE_W-1:0] phase;
    logic [7:0]         pins;
  } psld_scan_s;

  psld_scan_s q;
  psld_scan_s d;

  always_comb
  begin
    d = q;
    if (ce)
    begin
      if (!run)
      begin
        // Not running (direct style, or straps not yet captured): scan pins stay dark
        d = '0;
      end
      else
      begin
        if (q.cnt == LAST)
        begin
          d.cnt = '0;
          d.idx = q.idx + 2'h1;
        end
        else
        begin
          d.cnt = q.cnt + CW'(1);
        end
        d.phase = PHASE_W'(1) << d.idx;
        d.pins  = {link_lamp[d.idx], link_lamp[3'(d.idx) + 3'(GROUP)],
                   rate_lamp[d.idx], rate_lamp[3'(d.idx) + 3'(GROUP)],
                   duplex_lamp[d.idx], duplex_lamp[3'(d.idx) + 3'(GROUP)],
                   rx_lamp[d.idx], rx_lamp[3'(d.idx) + 3'(GROUP)]};
      end
    end
    if (sys_rst)
    begin
      d = '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    q <= d;
  end

  assign scan_phase    = q.phase;
  assign scan_link_a   = q.pins[7];
  assign scan_link_b   = q.pins[6];
  assign scan_rate_a   = q.pins[5];
  assign scan_rate_b   = q.pins[4];
  assign scan_duplex_a = q.pins[3];
  assign scan_duplex_b = q.pins[2];
  assign scan_rx_a     = q.pins[1];
  assign scan_rx_b     = q.pins[0];

endmodule // psld_scan

`default_nettype wire

// file: rtl/psld_top.sv
// Port status lamp driver: strap capture, lamp meanings, direct and scan drive, register slave
`timescale 1ns/1ps
`default_nettype none

module psld_top
  import psld_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_HALF_CYC,
  parameter int SCAN_CYC  = SCAN_STEP_CYC
)
(
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               ce,
  input  wire logic               lamp_drive_style_strap,
  input  wire logic [SEL_W-1:0]   lamp_meaning_select,
  input  wire logic [PORTS-1:0]   port_link_up,
  input  wire logic [PORTS-1:0]   port_speed_100,
  input  wire logic [PORTS-1:0]   port_full_duplex,
  input  wire logic [PORTS-1:0]   port_rx_active,
  input  wire logic [PORTS-1:0]   port_tx_active,
  input  wire logic [PORTS-1:0]   port_collision,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [WB_AW-1:0]   wb_adr_i,
  input  wire logic [WB_SW-1:0]   wb_sel_i,
  input  wire logic [WB_DW-1:0]   wb_dat_i,
  output var  logic [WB_DW-1:0]   wb_dat_o,
  output var  logic               wb_ack_o,
  output var  logic [PORTS-1:0]   port_link_lamp,
  output var  logic [PORTS-1:0]   port_rate_lamp,
  output var  logic [PORTS-1:0]   port_duplex_lamp,
  output var  logic [PHASE_W-1:0] scan_phase,
  output var  logic               scan_link_a,
  output var  logic               scan_link_b,
  output var  logic               scan_rate_a,
  output var  logic               scan_rate_b,
  output var  logic               scan_duplex_a,
  output var  logic               scan_duplex_b,
  output var  logic               scan_rx_a,
  output var  logic               scan_rx_b
);

  // Lamp states of one port: link, rate, duplex, rx
  typedef struct packed {
    logic link;
    logic rate;
    logic duplex;
    logic rx;
  } psld_lamp_s;

  typedef struct packed {
    logic                  style_s1;
    logic                  style_s2;
    logic [SEL_W-1:0]      sel_s1;
    logic [SEL_W-1:0]      sel_s2;
    logic                  in_reset;
    logic                  captured;
    logic                  style;
    logic [SEL_W-1:0]      sel;
    logic                  lamp_en;
    logic                  lamp_test;
    logic                  ack;
    logic [WB_DW-1:0]      rdata;
    logic [PORTS-1:0]      link_l;
    logic [PORTS-1:0]      rate_l;
    logic [PORTS-1:0]      dup_l;
  } psld_top_s;

  psld_top_s q;
  psld_top_s d;

  logic             blink;
  logic [PORTS-1:0] link_v;
  logic [PORTS-1:0] rate_v;
  logic [PORTS-1:0] dup_v;
  logic [PORTS-1:0] rx_v;
  logic             scan_run;

  // Steady or flashing lamp: flash wins while its trigger lasts
  function automatic logic lamp_level(input logic steady, input logic flash, input logic ph);
    lamp_level = flash ? ph : steady;
  endfunction

  // Meaning table for one port
  function automatic psld_lamp_s lamp_decode(
    input logic [SEL_W-1:0] code,
    input logic             link,
    input logic             fast,
    input logic             full,
    input logic             rx,
    input logic             tx,
    input logic             col,
    input logic             ph
  );
    psld_lamp_s r;
    logic       traffic;
    r       = '0;
    traffic = rx | tx;
    unique case (code)
      SEL_SPLIT_TXRX, SEL_SPLIT_COL:
      begin
        r.link = link & ~fast & lamp_level(1'h1, traffic, ph);
        r.rate = link & fast & lamp_level(1'h1, traffic, ph);
      end
      SEL_LINK_RX:
      begin
        r.link = link & lamp_level(1'h1, rx, ph);
        r.rate = link & fast;
      end
      SEL_LINK_TXRX:
      begin
        r.link = link & lamp_level(1'h1, traffic, ph);
        r.rate = link & fast;
      end
    endcase
    // Collisions only occur in half duplex, so the flash overrides a dark lamp
    r.duplex = lamp_level(link & full, col & (code != SEL_SPLIT_TXRX), ph);
    r.rx     = link & lamp_level(1'h0, rx, ph);
    lamp_decode = r;
  endfunction

  // Register address decode, shared by read and write paths
  function automatic logic is_reg(input logic [WB_AW-1:0] adr, input logic [WB_AW-1:0] reg_adr);
    is_reg = (adr == reg_adr);
  endfunction

  psld_blink #(
    .HALF_CYC    (BLINK_CYC)
  ) u_blink (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .ce          (ce),
    .blink_phase (blink)
  );

  genvar gp;
  generate
    for (gp = 0; gp < PORTS; gp++)
    begin : g_port
      psld_lamp_s lamp;
      assign lamp = lamp_decode(q.sel, port_link_up[gp], port_speed_100[gp], port_full_duplex[gp],
                                port_rx_active[gp], port_tx_active[gp], port_collision[gp], blink);
      // Lamp test lights everything while enabled; disable darkens everything, lamp test included
      assign link_v[gp] = q.lamp_en & (q.lamp_test | lamp.link);
      assign rate_v[gp] = q.lamp_en & (q.lamp_test | lamp.rate);
      assign dup_v[gp]  = q.lamp_en & (q.lamp_test | lamp.duplex);
      assign rx_v[gp]   = q.lamp_en & (q.lamp_test | lamp.rx);
    end
  endgenerate

  always_comb
  begin
    d = q;
    if (ce)
    begin
      // Pins are asynchronous to sys_clk: two stages before use
      d.style_s1 = lamp_drive_style_strap;
      d.style_s2 = q.style_s1;
      d.sel_s1   = lamp_meaning_select;
      d.sel_s2   = q.sel_s1;

      // Latch straps on the first enabled cycle after reset lets go
      d.in_reset = 1'h0;
      if (q.in_reset)
      begin
        d.style    = q.style_s2;
        d.sel      = q.sel_s2;
        d.captured = 1'h1;
      end

      // Direct outputs only carry lamps in direct style
      if (q.style == STYLE_DIRECT)
      begin
        d.link_l = link_v;
        d.rate_l = rate_v;
        d.dup_l  = dup_v;
      end
      else
      begin
        d.link_l = '0;
        d.rate_l = '0;
        d.dup_l  = '0;
      end

      // Classic single-cycle slave: ack one cycle after strobe, dropped next cycle
      d.ack   = wb_cyc_i & wb_stb_i & ~q.ack;
      d.rdata = '0;
      if (wb_cyc_i && wb_stb_i && !q.ack)
      begin
        if (wb_we_i)
        begin
          if (is_reg(wb_adr_i, REG_CTRL) && wb_sel_i[0])
          begin
            d.lamp_en   = wb_dat_i[CTRL_EN_BIT];
            d.lamp_test = wb_dat_i[CTRL_TEST_BIT];
          end
        end
        else if (is_reg(wb_adr_i, REG_CTRL))
        begin
          d.rdata[CTRL_EN_BIT]   = q.lamp_en;
          d.rdata[CTRL_TEST_BIT] = q.lamp_test;
        end
        else if (is_reg(wb_adr_i, REG_STATUS))
        begin
          d.rdata[STAT_STYLE_BIT]                   = q.style;
          d.rdata[STAT_SEL_LSB +: SEL_W]            = q.sel;
          d.rdata[STAT_BLINK_BIT]                   = blink;
          d.rdata[STAT_CAPT_BIT]                    = q.captured;
          d.rdata[STAT_LINK_LSB +: PORTS]           = port_link_up;
        end
      end
    end
    if (sys_rst)
    begin
      // Synchroniser stages keep sampling so the release sees the strap
      d.in_reset  = 1'h1;
      d.captured  = 1'h0;
      d.style     = STYLE_SCAN;
      d.sel       = SEL_RESET;
      d.lamp_en   = CTRL_EN_RST;
      d.lamp_test = CTRL_TEST_RST;
      d.ack       = 1'h0;
      d.rdata     = '0;
      d.link_l    = '0;
      d.rate_l    = '0;
      d.dup_l     = '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    q <= d;
  end

  assign scan_run = q.captured & (q.style == STYLE_SCAN);

  psld_scan #(
    .STEP_CYC      (SCAN_CYC)
  ) u_scan (
    .sys_clk       (sys_clk),
    .sys_rst       (sys_rst),
    .ce            (ce),
    .run           (scan_run),
    .link_lamp     (link_v),
    .rate_lamp     (rate_v),
    .duplex_lamp   (dup_v),
    .rx_lamp       (rx_v),
    .scan_phase    (scan_phase),
    .scan_link_a   (scan_link_a),
    .scan_link_b   (scan_link_b),
    .scan_rate_a   (scan_rate_a),
    .scan_rate_b   (scan_rate_b),
    .scan_duplex_a (scan_duplex_a),
    .scan_duplex_b (scan_duplex_b),
    .scan_rx_a     (scan_rx_a),
    .scan_rx_b     (scan_rx_b)
  );

  assign wb_dat_o         = q.rdata;
  assign wb_ack_o         = q.ack;
  assign port_link_lamp   = q.link_l;
  assign port_rate_lamp   = q.rate_l;
  assign port_duplex_lamp = q.dup_l;

endmodule // psld_top

`default_nettype wire

// file: test/psld_chk.sv
// Checker: port relations of the lamp driver
`timescale 1ns/1ps
`default_nettype none
module psld_chk
  import psld_pkg::*;
(
  input wire logic               sys_clk,
  input wire logic               sys_rst,
  input wire logic               ce,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_ack_o,
  input wire logic [WB_DW-1:0]   wb_dat_o,
  input wire logic [PORTS-1:0]   port_link_up,
  input wire logic [PORTS-1:0]   port_full_duplex,
  input wire logic [PORTS-1:0]   port_collision,
  input wire logic [PORTS-1:0]   port_link_lamp,
  input wire logic [PORTS-1:0]   port_rate_lamp,
  input wire logic [PORTS-1:0]   port_duplex_lamp,
  input wire logic [PHASE_W-1:0] scan_phase
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_ANSWER: assert property (s_req |=> s_ans) else $error("ack not a one cycle answer");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("read data outside ack");
  AST_PHASE_ONEHOT: assert property ($onehot0(scan_phase)) else $error("scan phase not one-hot");
  AST_MODE_EXCL: assert property ((port_link_lamp | port_rate_lamp | port_duplex_lamp) != '0
    |-> scan_phase == '0) else $error("direct lamps lit in scan style");
  AST_LINK_OFF: assert property ($past(ce) |-> (port_link_lamp & ~$past(port_link_up)) == '0)
    else $error("link lamp lit on link failure");
  AST_RATE_OFF: assert property ($past(ce) |-> (port_rate_lamp & ~$past(port_link_up)) == '0)
    else $error("rate lamp lit on link failure");
  AST_DUPLEX_HALF: assert property ($past(ce) && $past(port_collision) == '0
    |-> (port_duplex_lamp & ~($past(port_link_up) & $past(port_full_duplex))) == '0)
    else $error("duplex lamp lit for half duplex");
endmodule // psld_chk
bind psld_top psld_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .port_link_up(port_link_up),
  .port_full_duplex(port_full_duplex), .port_collision(port_collision), .port_link_lamp(port_link_lamp),
  .port_rate_lamp(port_rate_lamp), .port_duplex_lamp(port_duplex_lamp), .scan_phase(scan_phase));
`default_nettype wire

// file: test/psld_board.sv
// Board model: strap resistors seen by the lamp driver
`timescale 1ns/1ps
`default_nettype none
module psld_board
  import psld_pkg::*;
(
  input  wire logic             style_pull_up,
  input  wire logic [SEL_W-1:0] sel_level,
  output var  logic             strap_pin,
  output var  logic [SEL_W-1:0] sel_pin
);
  // Open pin falls to the internal pull-down, never floats
  assign strap_pin = style_pull_up ? 1'h1 : 1'h0;
  assign sel_pin   = sel_level;
endmodule // psld_board
`default_nettype wire

// file: test/psld_top_tb_top.sv
// Testbench: strap capture, direct lamp meanings, flashing, register access
`timescale 1ns/1ps
`default_nettype none
module psld_top_tb_top
  import psld_pkg::*;
;
  logic sys_clk, sys_rst, ce, pull_up, strap, cyc, stb, we, ack;
  logic [SEL_W-1:0] sel_lv, msel;
  logic [PORTS-1:0] link, fast, full, rx, tx, col, llamp, rlamp, dlamp;
  logic [WB_AW-1:0] adr;
  logic [WB_SW-1:0] bsel;
  logic [WB_DW-1:0] wdat, rdat, r;
  logic [PHASE_W-1:0] phase;
  int num_errors, checks, cnt, k;
  logic last;
  wire [7:0] spins;
  psld_board u_board (.style_pull_up(pull_up), .sel_level(sel_lv), .strap_pin(strap), .sel_pin(msel));
  psld_top #(.BLINK_CYC(4), .SCAN_CYC(3)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
    .lamp_drive_style_strap(strap), .lamp_meaning_select(msel), .port_link_up(link),
    .port_speed_100(fast), .port_full_duplex(full), .port_rx_active(rx), .port_tx_active(tx),
    .port_collision(col), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(bsel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .port_link_lamp(llamp),
    .port_rate_lamp(rlamp), .port_duplex_lamp(dlamp), .scan_phase(phase), .scan_link_a(spins[7]),
    .scan_link_b(spins[6]), .scan_rate_a(spins[5]), .scan_rate_b(spins[4]), .scan_duplex_a(spins[3]),
    .scan_duplex_b(spins[2]), .scan_rx_a(spins[1]), .scan_rx_b(spins[0]));
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [WB_DW-1:0] exp, input logic [WB_DW-1:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [WB_AW-1:0] a, input logic [WB_DW-1:0] d);
    @(posedge sys_clk);
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; wdat <= d; bsel <= 4'hF;
    do
    begin
      @(posedge sys_clk);
    end while (ack !== 1'h1);
    r = rdat;
    cyc <= 1'h0; stb <= 1'h0; we <= 1'h0;
  endtask
  // Straps flipped after release: a late sample would show
  task automatic do_reset(input logic s, input logic [1:0] c);
    @(posedge sys_clk);
    sys_rst <= 1'h1; pull_up <= s; sel_lv <= c;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'h0;
    repeat (3) @(posedge sys_clk);
    pull_up <= ~s; sel_lv <= ~c;
  endtask
  function automatic logic [7:0] exp_link(logic [1:0] c, logic [7:0] l, logic [7:0] f);
    return c[0] ? l : (l & ~f);
  endfunction
  // Scan pins of the active phase: port i on a, port i+4 on b
  function automatic logic [7:0] exp_scan(logic [1:0] c, logic [3:0] ph, logic [7:0] l, logic [7:0] f,
                                          logic [7:0] u);
    logic [7:0] el;
    logic [7:0] er;
    logic [7:0] ed;
    int i;
    el = exp_link(c, l, f);
    er = l & f;
    ed = l & u;
    i = 0;
    for (int j = 0; j < 4; j++)
      if (ph[j])
        i = j;
    return {el[i], el[i + 4], er[i], er[i + 4], ed[i], ed[i + 4], 2'h0};
  endfunction
  task automatic flash_case(input logic [1:0] c, input int trig, input int lamp, input logic exp);
    do_reset(1'h1, c);
    link <= 8'hFF; fast <= 8'hFF; full <= 8'hFF;
    rx <= (trig == 0) ? 8'h08 : 8'h00; tx <= (trig == 1) ? 8'h08 : 8'h00;
    col <= (trig == 2) ? 8'h08 : 8'h00;
    repeat (4) @(posedge sys_clk);
    cnt = 0;
    for (k = 0; k < 25; k++)
    begin
      @(negedge sys_clk);
      last = (lamp == 0) ? llamp[3] : (lamp == 1) ? rlamp[3] : dlamp[3];
      @(posedge sys_clk);
      #1 cnt += (last !== ((lamp == 0) ? llamp[3] : (lamp == 1) ? rlamp[3] : dlamp[3]));
    end
    cmp("flashing", exp, cnt >= 3);
    rx <= 8'h00; tx <= 8'h00; col <= 8'h00;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp("steady", {c[0], 2'h3}, {llamp[3], rlamp[3], dlamp[3]});
    $display("flash case code %0d trig %0d done", c, trig);
  endtask
  initial
  begin
    #200_000;
    num_errors++;
    stop_test();
  end
  initial
  begin
    num_errors = 0; checks = 0; void'($urandom(32'h7821));
    sys_rst = 1'h1; ce = 1'h1; pull_up = 1'h0; sel_lv = 2'h3; cyc = 1'h0; stb = 1'h0; we = 1'h0;
    adr = 4'h0; bsel = 4'h0; wdat = 32'h0; link = 8'h0; fast = 8'h0; full = 8'h0;
    rx = 8'h0; tx = 8'h0; col = 8'h0;
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 4; c++)
      begin
        do_reset(s[0], c[1:0]);
        repeat (20)
        begin
          @(posedge sys_clk);
          link <= 8'($urandom); fast <= 8'($urandom); full <= 8'($urandom);
          @(posedge sys_clk);
          @(negedge sys_clk);
          cmp("link_lamp", s ? exp_link(c[1:0], link, fast) : 8'h0, llamp);
          cmp("rate_lamp", s ? (link & fast) : 8'h0, rlamp);
          cmp("duplex_lamp", s ? (link & full) : 8'h0, dlamp);
          cmp("scan_pins", s ? 8'h0 : exp_scan(c[1:0], phase, link, fast, full), spins);
        end
        cmp("scan_running", !s, phase != '0);
        wb(1'h0, REG_STATUS, 32'h0);
        cmp("status", {16'h0, link, 3'h0, 1'h1, 1'h0, c[1:0], s[0]}, r & 32'h0000FF17);
        $display("capture test style %0d code %0d done", s, c);
      end
    flash_case(2'h3, 0, 0, 1'h1);
    flash_case(2'h1, 1, 0, 1'h0);
    flash_case(2'h0, 1, 1, 1'h1);
    flash_case(2'h0, 2, 2, 1'h0);
    flash_case(2'h2, 2, 2, 1'h1);
    wb(1'h1, REG_CTRL, 32'h0);
    repeat (3) @(negedge sys_clk);
    cmp("lamps_disabled", 32'h0, {llamp, rlamp, dlamp});
    wb(1'h1, REG_CTRL, 32'h1);
    wb(1'h1, 4'h8, 32'hFFFFFFFF);
    wb(1'h0, 4'h8, 32'h0);
    cmp("unmapped_read", 32'h0, r);
    wb(1'h0, REG_CTRL, 32'h0);
    cmp("ctrl_read", 32'h1, r & 32'h3);
    // Enable low: lamps hold although the link drops
    @(posedge sys_clk);
    ce <= 1'h0;
    link <= 8'h00;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp("frozen", {8'h00, 8'hFF, 8'hFF}, {llamp, rlamp, dlamp});
    @(posedge sys_clk);
    ce <= 1'h1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp("thawed", 24'h0, {llamp, rlamp, dlamp});
    @(posedge sys_clk);
    link <= 8'hFF;
    wb(1'h1, REG_CTRL, 32'h3);
    repeat (2) @(negedge sys_clk);
    cmp("lamp_test", 24'hFFFFFF, {llamp, rlamp, dlamp});
    $display("register test done");
    stop_test();
  end
endmodule // psld_top_tb_top
`default_nettype wire
